// >>> verilog/logic_cell_pkg.sv
package logic_cell_pkg;

	// register map, byte addresses on the 12-bit bus address
	localparam logic [11:0] cfg_addr    = 12'h000;
	localparam logic [11:0] lut_addr    = 12'h004;
	localparam logic [11:0] status_addr = 12'h008;

	// reset values
	localparam logic [11:0] cfg_reset = 12'h000;
	localparam logic [15:0] lut_reset = 16'h0000;

	// status bit positions
	localparam int status_q_bit       = 0;
	localparam int status_comb_bit    = 1;
	localparam int status_carry_bit   = 2;
	localparam int status_cascade_bit = 3;
	localparam int status_bus_bit     = 4;

	// bus answers
	localparam logic [1:0] resp_okay   = 2'h0;
	localparam logic [1:0] resp_slverr = 2'h2;

	// fixed counter tables, index {carry, enable or up, q}
	localparam logic [7:0] count_table = 8'h6a;
	localparam logic [7:0] carry_table = 8'h90;

	// offset of the carry table inside the lookup word in arithmetic mode
	localparam int arith_carry_base = 8;

	// drivers on the emulated internal bus
	localparam int bus_drivers = 4;

	typedef enum logic [1:0] {
		mode_normal,
		mode_arith,
		mode_counter
	} mode_t;

	// configuration word, bit 0 upward: mode, then the option flags
	typedef struct packed {
		logic       load_hold;
		logic       fb_carry;
		logic       local_ctrl;
		logic       greset_en;
		logic       preset_mode;
		logic       clr_sel_b;
		logic       clr_en;
		logic       reg_out;
		logic       cascade_en;
		logic       lut_d_carry;
		logic [1:0] mode;
	} cfg_t;

	// cluster-wide register controls
	typedef struct packed {
		logic async_a_n;
		logic async_b_n;
		logic sync_clear;
		logic sync_load;
	} ctrl_t;

endpackage

// >>> verilog/logic_cell.sv
// Decided for this implementation: the register offsets and the AXI4-Lite interface to the registers.
`timescale 1ns/1ps

module logic_cell
	import logic_cell_pkg::*;
(
	input  wire logic                   aclk,
	input  wire logic                   aresetn,
	input  wire logic [11:0]            s_axi_awaddr,
	input  wire logic                   s_axi_awvalid,
	output logic                        s_axi_awready,
	input  wire logic [31:0]            s_axi_wdata,
	input  wire logic [3:0]             s_axi_wstrb,
	input  wire logic                   s_axi_wvalid,
	output logic                        s_axi_wready,
	output logic [1:0]                  s_axi_bresp,
	output logic                        s_axi_bvalid,
	input  wire logic                   s_axi_bready,
	input  wire logic [11:0]            s_axi_araddr,
	input  wire logic                   s_axi_arvalid,
	output logic                        s_axi_arready,
	output logic [31:0]                 s_axi_rdata,
	output logic [1:0]                  s_axi_rresp,
	output logic                        s_axi_rvalid,
	input  wire logic                   s_axi_rready,
	input  wire logic                   operand_a_in,
	input  wire logic                   operand_b_in,
	input  wire logic                   operand_c_in,
	input  wire logic                   operand_d_in,
	input  wire logic                   carry_in,
	input  wire logic                   cascade_in,
	input  wire logic                   cluster_ctrl_a,
	input  wire logic                   cluster_ctrl_b,
	input  wire logic                   cluster_sync_clear,
	input  wire logic                   cluster_sync_load,
	input  wire logic                   global_reset_n,
	input  wire logic [3:0]             lead_operand,
	input  wire logic [bus_drivers-1:0] bus_oe,
	input  wire logic [bus_drivers-1:0] bus_data,
	output logic                        cell_out,
	output logic                        carry_out,
	output logic                        cascade_out,
	output logic                        bus_out
);

	// 3-input lookup, shared by arithmetic and counter paths
	function automatic logic lut3(input logic [7:0] table_bits, input logic [2:0] idx);
		lut3 = table_bits[idx];
	endfunction

	// byte-lane merge for register writes
	function automatic logic [31:0] merge(input logic [31:0] old_val,
		input logic [31:0] new_val, input logic [3:0] strb);
		logic [31:0] res;
		res = old_val;
		for (int i = 0; i < 4; i++) begin
			if (strb[i]) begin
				res[8*i +: 8] = new_val[8*i +: 8];
			end
		end
		merge = res;
	endfunction

	// address decode, used on both the write and read paths
	function automatic logic addr_known(input logic [11:0] addr);
		addr_known = (addr == cfg_addr) || (addr == lut_addr) || (addr == status_addr);
	endfunction

	cfg_t        cfg;
	logic [15:0] lut_mask;
	mode_t       mode;
	ctrl_t       ctrl;
	logic        aw_got;
	logic        w_got;
	logic [11:0] aw_addr;
	logic [31:0] w_data;
	logic [3:0]  w_strb;
	logic        wr_fire;
	logic        stored;
	logic        q_out;
	logic        cin;
	logic        lut_out;
	logic        pre_ctrl;
	logic        comb_result;
	logic        load_data;
	logic        next_q;
	logic        cluster_clr_n;
	logic        async_clr_n;
	logic [31:0] status_word;

	assign mode = mode_t'(cfg.mode);

	// cluster controls: dedicated lines or the lead cell's inputs
	always_comb begin
		if (cfg.local_ctrl) begin
			ctrl = {lead_operand[0], lead_operand[1], lead_operand[2], lead_operand[3]};
		end else begin
			ctrl = {cluster_ctrl_a, cluster_ctrl_b, cluster_sync_clear, cluster_sync_load};
		end
	end

	// async clear: chosen line, unused reads high, chip reset gated in
	assign cluster_clr_n = cfg.clr_en ? (cfg.clr_sel_b ? ctrl.async_b_n : ctrl.async_a_n)
		: 1'b1;
	assign async_clr_n = cluster_clr_n & (cfg.greset_en ? global_reset_n : 1'b1);

	// own-output fast feedback starts a counter chain here
	assign cin = (mode == mode_counter && cfg.fb_carry) ? q_out : carry_in;

	// per-mode datapath; operands a to d, carry and q go to different tables
	always_comb begin
		lut_out   = 1'b0;
		carry_out = 1'b0;
		case (mode)
			mode_arith: begin
				lut_out   = lut3(lut_mask[7:0], {cin, operand_b_in, operand_a_in});
				carry_out = lut3(lut_mask[arith_carry_base +: 8],
					{cin, operand_b_in, operand_a_in});
			end
			mode_counter: begin
				lut_out   = lut3(count_table, {cin, operand_a_in, q_out});
				carry_out = lut3(carry_table, {cin, operand_b_in, q_out});
			end
			default: begin
				lut_out = lut_mask[{operand_d_in, (cfg.lut_d_carry ? cin : operand_c_in),
					operand_b_in, operand_a_in}];
			end
		endcase
	end

	// cascade joins the table output in every mode when enabled
	assign pre_ctrl    = cfg.cascade_en ? (lut_out & cascade_in) : lut_out;
	assign cascade_out = pre_ctrl;
	assign comb_result = pre_ctrl;

	// sync controls: load mux then clear AND; clear beats load
	assign load_data = cfg.load_hold ? q_out : operand_c_in;
	always_comb begin
		if (ctrl.sync_clear) begin
			next_q = 1'b0;
		end else if (ctrl.sync_load) begin
			next_q = load_data;
		end else begin
			next_q = pre_ctrl;
		end
	end

	// cell register; preset mode stores the inverse so clear means high
	always_ff @(posedge aclk or negedge async_clr_n) begin
		if (!async_clr_n) begin
			stored <= 1'b0;
		end else if (!aresetn) begin
			stored <= 1'b0;
		end else begin
			stored <= cfg.preset_mode ? ~next_q : next_q;
		end
	end
	assign q_out    = cfg.preset_mode ? ~stored : stored;
	assign cell_out = cfg.reg_out ? q_out : comb_result;

	// emulated internal bus: one driver wins, none is high, many low
	always_comb begin
		if (bus_oe == '0) begin
			bus_out = 1'b1;
		end else if ((bus_oe & (bus_oe - bus_drivers'(1))) != '0) begin
			bus_out = 1'b0;
		end else begin
			bus_out = |(bus_oe & bus_data);
		end
	end

	// write channel capture; address and data in either order
	assign s_axi_awready = !aw_got && !s_axi_bvalid;
	assign s_axi_wready  = !w_got && !s_axi_bvalid;
	assign wr_fire       = aw_got && w_got;
	always_ff @(posedge aclk) begin
		if (!aresetn) begin
			aw_got  <= 1'b0;
			w_got   <= 1'b0;
			aw_addr <= 12'h000;
			w_data  <= 32'h0000_0000;
			w_strb  <= 4'h0;
		end else if (wr_fire) begin
			aw_got <= 1'b0;
			w_got  <= 1'b0;
		end else begin
			if (s_axi_awvalid && s_axi_awready) begin
				aw_got  <= 1'b1;
				aw_addr <= s_axi_awaddr;
			end
			if (s_axi_wvalid && s_axi_wready) begin
				w_got  <= 1'b1;
				w_data <= s_axi_wdata;
				w_strb <= s_axi_wstrb;
			end
		end
	end

	// configuration and table registers; status writes are dropped
	always_ff @(posedge aclk) begin
		if (!aresetn) begin
			cfg      <= cfg_t'(cfg_reset);
			lut_mask <= lut_reset;
		end else if (wr_fire) begin
			if (aw_addr == cfg_addr) begin
				// a function result cannot be part-selected, so cut it by a size cast
				cfg <= cfg_t'(12'(merge({20'h0_0000, cfg}, w_data, w_strb)));
			end
			if (aw_addr == lut_addr) begin
				lut_mask <= 16'(merge({16'h0000, lut_mask}, w_data, w_strb));
			end
		end
	end

	// write response one edge after both halves are in
	always_ff @(posedge aclk) begin
		if (!aresetn) begin
			s_axi_bvalid <= 1'b0;
			s_axi_bresp  <= resp_okay;
		end else if (wr_fire) begin
			s_axi_bvalid <= 1'b1;
			s_axi_bresp  <= addr_known(aw_addr) ? resp_okay : resp_slverr;
		end else if (s_axi_bready) begin
			s_axi_bvalid <= 1'b0;
		end
	end

	// live cell state for software
	always_comb begin
		status_word                     = 32'h0000_0000;
		status_word[status_q_bit]       = q_out;
		status_word[status_comb_bit]    = comb_result;
		status_word[status_carry_bit]   = carry_out;
		status_word[status_cascade_bit] = cascade_out;
		status_word[status_bus_bit]     = bus_out;
	end

	// read path; unmapped reads answer zero with an error
	assign s_axi_arready = !s_axi_rvalid;
	always_ff @(posedge aclk) begin
		if (!aresetn) begin
			s_axi_rvalid <= 1'b0;
			s_axi_rdata  <= 32'h0000_0000;
			s_axi_rresp  <= resp_okay;
		end else if (s_axi_arvalid && s_axi_arready) begin
			s_axi_rvalid <= 1'b1;
			s_axi_rresp  <= addr_known(s_axi_araddr) ? resp_okay : resp_slverr;
			case (s_axi_araddr)
				cfg_addr:    s_axi_rdata <= {20'h0_0000, cfg};
				lut_addr:    s_axi_rdata <= {16'h0000, lut_mask};
				status_addr: s_axi_rdata <= status_word;
				default:     s_axi_rdata <= 32'h0000_0000;
			endcase
		end else if (s_axi_rready) begin
			s_axi_rvalid <= 1'b0;
		end
	end

	// checks on the cell register, the datapath, the bus and the write response
	chk_clear_beats_load: assert property (
		@(posedge aclk) disable iff (!aresetn || !async_clr_n)
		ctrl.sync_clear ##1 async_clr_n |-> q_out == 1'b0)
		else $error("sync clear did not clear the register");

	chk_load_over_cascade: assert property (
		@(posedge aclk) disable iff (!aresetn || !async_clr_n)
		(!ctrl.sync_clear && ctrl.sync_load) ##1 async_clr_n
		|-> q_out == $past(load_data))
		else $error("sync load value not taken");

	chk_count_hold: assert property (
		@(posedge aclk) disable iff (!aresetn || !async_clr_n)
		(mode == mode_counter && !cfg.cascade_en && !ctrl.sync_clear
		&& !ctrl.sync_load && !operand_a_in) ##1 async_clr_n
		|-> $stable(q_out))
		else $error("counter moved without enable");

	chk_count_step: assert property (
		@(posedge aclk) disable iff (!aresetn || !async_clr_n)
		(mode == mode_counter && !cfg.cascade_en && !ctrl.sync_clear
		&& !ctrl.sync_load && operand_a_in && cin) ##1 async_clr_n
		|-> q_out != $past(q_out))
		else $error("enabled counter with carry did not toggle");

	chk_async_preset: assert property (
		@(posedge aclk) disable iff (!aresetn)
		!async_clr_n |-> q_out == cfg.preset_mode)
		else $error("async clear gave wrong output level");

	chk_arith_carry: assert property (
		@(posedge aclk) disable iff (!aresetn)
		mode == mode_arith
		|-> carry_out == lut_mask[arith_carry_base + {cin, operand_b_in, operand_a_in}])
		else $error("arithmetic carry out wrong");

	chk_bus_resolve: assert property (
		@(posedge aclk) disable iff (!aresetn)
		($countones(bus_oe) > 1 |-> !bus_out) and (bus_oe == '0 |-> bus_out))
		else $error("emulated bus resolved wrongly");

	chk_cascade_and: assert property (
		@(posedge aclk) disable iff (!aresetn)
		(cfg.cascade_en && !cascade_in) |-> !cascade_out)
		else $error("cascade in low did not force cascade out low");

	chk_bresp_stable: assert property (
		@(posedge aclk) disable iff (!aresetn)
		(s_axi_bvalid && !s_axi_bready) |=> s_axi_bvalid && $stable(s_axi_bresp))
		else $error("write response dropped before bready");

	// direction only steers the fast carry, enable only the bit toggle
	chk_counter_carry: assert property (
		@(posedge aclk) disable iff (!aresetn)
		mode == mode_counter
		|-> carry_out == (cin & (operand_b_in ? q_out : !q_out)))
		else $error("counter carry out wrong");

	// load fed from own output must act as a hold
	chk_load_hold: assert property (
		@(posedge aclk) disable iff (!aresetn || !async_clr_n)
		(cfg.load_hold && !ctrl.sync_clear && ctrl.sync_load) ##1 async_clr_n
		|-> $stable(q_out))
		else $error("held load changed the register");

endmodule

// >>> testbench/tb.sv
`timescale 1ns/1ps

module tb;
	import logic_cell_pkg::*;
	logic        aclk, aresetn, awvalid, wvalid, bready, arvalid, rready;
	logic        awready, wready, bvalid, arready, rvalid;
	logic [11:0] awaddr, araddr;
	logic [31:0] wdata, rdata;
	logic [1:0]  bresp, rresp;
	logic        op_a, op_b, op_c, op_d, cin, cas_in, ctl_a, ctl_b, s_clr, s_ld, grst_n;
	logic [3:0]  lead, oe, bdat, strb;
	logic        c_out, cy_out, cas_out, b_out;
	int          error_cnt, tests_run, cyc;

	logic_cell dut (
		.aclk(aclk), .aresetn(aresetn),
		.s_axi_awaddr(awaddr), .s_axi_awvalid(awvalid), .s_axi_awready(awready),
		.s_axi_wdata(wdata), .s_axi_wstrb(strb), .s_axi_wvalid(wvalid),
		.s_axi_wready(wready), .s_axi_bresp(bresp), .s_axi_bvalid(bvalid),
		.s_axi_bready(bready), .s_axi_araddr(araddr), .s_axi_arvalid(arvalid),
		.s_axi_arready(arready), .s_axi_rdata(rdata), .s_axi_rresp(rresp),
		.s_axi_rvalid(rvalid), .s_axi_rready(rready),
		.operand_a_in(op_a), .operand_b_in(op_b), .operand_c_in(op_c),
		.operand_d_in(op_d), .carry_in(cin), .cascade_in(cas_in),
		.cluster_ctrl_a(ctl_a), .cluster_ctrl_b(ctl_b), .cluster_sync_clear(s_clr),
		.cluster_sync_load(s_ld), .global_reset_n(grst_n), .lead_operand(lead),
		.bus_oe(oe), .bus_data(bdat), .cell_out(c_out), .carry_out(cy_out),
		.cascade_out(cas_out), .bus_out(b_out)
	);

	initial begin
		aclk = 0;
		forever #5 aclk = ~aclk;
	end

	task automatic report_and_stop();
		$display("checks %0d errors %0d", tests_run, error_cnt);
		if (error_cnt == 0 && tests_run > 0) $display("verification passed");
		else $display("verification failed");
		$finish;
	endtask

	// hang guard, whole run is a few hundred cycles
	always @(posedge aclk) begin
		cyc <= cyc + 1;
		if (cyc == 20000) begin
			error_cnt++;
			report_and_stop();
		end
	end

	task automatic chk(input string nm, input logic [31:0] e, input logic [31:0] g);
		tests_run++;
		if (g !== e) begin
			error_cnt++;
			$display("Error %s expected %h seen %h", nm, e, g);
		end
	endtask

	// handshakes judged at the negedge, where ready and valid are settled
	task automatic wr(input logic [11:0] a, input logic [31:0] d, input logic [1:0] er);
		bit ta, tw, tb_;
		logic [1:0] r;
		@(posedge aclk);
		awaddr <= a;
		wdata <= d;
		awvalid <= 1;
		wvalid <= 1;
		bready <= 1;
		do begin
			@(negedge aclk);
			ta = awvalid && awready;
			tw = wvalid && wready;
			tb_ = bvalid;
			r = bresp;
			@(posedge aclk);
			if (ta) awvalid <= 0;
			if (tw) wvalid <= 0;
		end while (!tb_);
		bready <= 0;
		chk("bresp", {30'h0, er}, {30'h0, r});
	endtask

	task automatic rd(input logic [11:0] a, input logic [31:0] e, input logic [1:0] er);
		bit ta, tr;
		logic [31:0] d;
		logic [1:0] r;
		@(posedge aclk);
		araddr <= a;
		arvalid <= 1;
		rready <= 1;
		do begin
			@(negedge aclk);
			ta = arvalid && arready;
			tr = rvalid;
			d = rdata;
			r = rresp;
			@(posedge aclk);
			if (ta) arvalid <= 0;
		end while (!tr);
		rready <= 0;
		chk("rdata", e, d);
		chk("rresp", {30'h0, er}, {30'h0, r});
	endtask

	// cell inputs {a, b, c, d, carry, cascade, sync clear, sync load}
	task automatic ops(input logic [7:0] v);
		@(posedge aclk);
		{op_a, op_b, op_c, op_d, cin, cas_in, s_clr, s_ld} <= v;
		@(negedge aclk);
	endtask

	task automatic t_regs();
		rd(cfg_addr, 32'h0, resp_okay);
		rd(lut_addr, 32'h0, resp_okay);
		wr(12'h00c, 32'h1234_5678, resp_slverr);
		rd(12'h00c, 32'h0, resp_slverr);
		wr(status_addr, 32'hffff_ffff, resp_okay);
		wr(lut_addr, 32'hffff_8000, resp_okay);
		rd(lut_addr, 32'h0000_8000, resp_okay);
		strb <= 4'h1;
		wr(lut_addr, 32'h0000_ff00, resp_okay);
		strb <= 4'hf;
		rd(lut_addr, 32'h0000_8000, resp_okay);
	endtask

	task automatic t_normal();
		ops(8'hf0);
		chk("and4", 1, c_out);
		rd(status_addr, 32'h0000_001b, resp_okay);
		ops(8'he0);
		chk("and4_d0", 0, c_out);
		wr(cfg_addr, 32'h00c, resp_okay);
		ops(8'hd8);
		chk("cascade_lo", 0, cas_out);
		ops(8'hdc);
		chk("carry_idx", 1, c_out);
		chk("cascade_hi", 1, cas_out);
		wr(cfg_addr, 32'h014, resp_okay);
		ops(8'hd8);
		ops(8'hd8);
		chk("reg_q", 1, c_out);
	endtask

	// every carry, a, b and cascade combination, cascade chain off then on
	task automatic t_arith();
		logic [3:0] i;
		logic       en;
		wr(lut_addr, 32'h0000_e896, resp_okay);
		for (int m = 0; m < 2; m++) begin
			en = m[0];
			wr(cfg_addr, en ? 32'h009 : 32'h001, resp_okay);
			for (int k = 0; k < 16; k++) begin
				i = 4'(k);
				ops({i[0], i[1], 2'b00, i[2], i[3], 2'b00});
				chk("sum", (^i[2:0]) & (i[3] | !en), c_out);
				chk("carry", (i[0] & i[1]) | (i[2] & (i[0] | i[1])), cy_out);
				chk("casc_ar", (^i[2:0]) & (i[3] | !en), cas_out);
			end
		end
	endtask

	task automatic t_count();
		wr(cfg_addr, 32'h012, resp_okay);
		ops(8'h23);
		ops(8'h23);
		chk("clr_wins", 0, c_out);
		ops(8'h21);
		ops(8'h21);
		chk("load", 1, c_out);
		ops(8'hc8);
		chk("carry_up", 1, cy_out);
		ops(8'hc8);
		chk("count", 0, c_out);
		ops(8'h88);
		chk("carry_dn", 0, cy_out);
		ops(8'h48);
		ops(8'h48);
		chk("hold", 0, c_out);
		wr(cfg_addr, 32'h01a, resp_okay);
		ops(8'h21);
		ops(8'h21);
		chk("casc_ovr", 1, c_out);
		wr(cfg_addr, 32'h812, resp_okay);
		ops(8'h01);
		ops(8'h01);
		chk("load_hold", 1, c_out);
		wr(cfg_addr, 32'h412, resp_okay);
		ops(8'h21);
		ops(8'h80);
		ops(8'h80);
		chk("fb_carry", 0, c_out);
	endtask

	task automatic t_async();
		wr(lut_addr, 32'h0000_ffff, resp_okay);
		wr(cfg_addr, 32'h030, resp_okay);
		ops(8'h00);
		ops(8'h00);
		@(posedge aclk);
		ctl_b <= 0;
		@(negedge aclk);
		chk("sel_a_only", 1, c_out);
		@(posedge aclk);
		ctl_b <= 1;
		ctl_a <= 0;
		@(negedge aclk);
		chk("async_clr", 0, c_out);
		@(posedge aclk);
		ctl_a <= 1;
		wr(lut_addr, 32'h0, resp_okay);
		wr(cfg_addr, 32'h0f0, resp_okay);
		ctl_b <= 0;
		@(negedge aclk);
		chk("preset", 1, c_out);
		@(posedge aclk);
		ctl_b <= 1;
		wr(cfg_addr, 32'h190, resp_okay);
		ops(8'h00);
		@(posedge aclk);
		grst_n <= 0;
		@(negedge aclk);
		chk("greset_pre", 1, c_out);
		@(posedge aclk);
		grst_n <= 1;
		wr(lut_addr, 32'h0000_ffff, resp_okay);
		wr(cfg_addr, 32'h110, resp_okay);
		grst_n <= 0;
		ops(8'h21);
		chk("greset", 0, c_out);
		@(posedge aclk);
		grst_n <= 1;
		wr(cfg_addr, 32'h210, resp_okay);
		ops(8'h00);
		@(posedge aclk);
		lead <= 4'b0111;
		ops(8'h00);
		chk("lead_clr", 0, c_out);
		@(posedge aclk);
		lead <= 4'b0011;
	endtask

	task automatic t_bus();
		for (int k = 0; k < 32; k++) begin
			@(posedge aclk);
			oe <= 4'(k);
			bdat <= k[4] ? 4'(k) : ~4'(k);
			@(negedge aclk);
			chk("bus", (oe == 0) ? 1 : ($countones(oe) > 1) ? 0 : k[4], b_out);
		end
	endtask

	initial begin
		{awvalid, wvalid, bready, arvalid, rready, aresetn} = 0;
		{awaddr, araddr, wdata, cyc, error_cnt, tests_run} = 0;
		{op_a, op_b, op_c, op_d, cin, cas_in, s_clr, s_ld, oe, bdat} = 0;
		{ctl_a, ctl_b, grst_n} = 3'b111;
		lead = 4'b0011;
		strb = 4'hf;
		repeat (2) @(posedge aclk);
		aresetn <= 1;
		t_regs();
		t_normal();
		t_arith();
		t_count();
		t_async();
		t_bus();
		report_and_stop();
	end
endmodule
